/* hdl/assrc_pkg.sv */
// Package for the axis stop, error clear and state record command block
package assrc_pkg;
  localparam logic [1:0] ASSRC_AXIS_X = 2'h0;
  localparam logic [1:0] ASSRC_AXIS_Y = 2'h1;
  localparam logic [1:0] ASSRC_CMD_HALT = 2'h0;
  localparam logic [1:0] ASSRC_CMD_CLEAR = 2'h1;
  localparam logic [1:0] ASSRC_CMD_SRD = 2'h2;
  localparam logic [1:0] ASSRC_CMD_GET = 2'h3;
  localparam logic [15:0] ASSRC_INHIBIT_KEEP = 16'h0000;
  localparam logic [15:0] ASSRC_INHIBIT_CANCEL = 16'h0001;
  localparam logic [15:0] ASSRC_STATE_BASE_X = 16'h01c0;
  localparam logic [15:0] ASSRC_STATE_SPAN = 16'h0020;
  localparam logic [3:0] ASSRC_REC_WORDS = 4'hd;
  localparam logic [3:0] ASSRC_REC_LAST = 4'hc;
  localparam logic [3:0] ASSRC_W_UP = 4'h0;
  localparam logic [3:0] ASSRC_W_DOWN = 4'h1;
  localparam logic [3:0] ASSRC_W_INFO = 4'h2;
  localparam logic [3:0] ASSRC_W_IO = 4'h3;
  localparam logic [3:0] ASSRC_W_POS_LO = 4'h4;
  localparam logic [3:0] ASSRC_W_POS_HI = 4'h5;
  localparam logic [3:0] ASSRC_W_SPD_LO = 4'h6;
  localparam logic [3:0] ASSRC_W_SPD_HI = 4'h7;
  localparam logic [3:0] ASSRC_W_STEP = 4'h8;
  localparam logic [3:0] ASSRC_W_MCODE = 4'h9;
  localparam logic [3:0] ASSRC_W_ERR = 4'ha;
  localparam logic [3:0] ASSRC_W_ENC_LO = 4'hb;
  localparam logic [3:0] ASSRC_W_ENC_HI = 4'hc;
  localparam logic [15:0] ASSRC_WORD_RESET = 16'h0000;
  typedef enum logic [2:0] {
    ASSRC_ST_IDLE = 3'h1,
    ASSRC_ST_SEND = 3'h2,
    ASSRC_ST_DONE = 3'h4
  } assrc_state_t;
endpackage

/* hdl/assrc_axis_flags.sv */
// Per-axis halt, error and inhibit flags
`timescale 1ns/10ps
module assrc_axis_flags (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic halt_i,
  input wire logic clear_i,
  input wire logic cancel_inhibit_i,
  input wire logic error_set_i,
  input wire logic inhibit_set_i,
  output logic halted_o,
  output logic error_o,
  output logic inhibit_o
);
  logic halted_q, halted_d, error_q, error_d, inhibit_q, inhibit_d;

  always_comb begin
    halted_d = halted_q | halt_i;
    error_d = error_q;
    inhibit_d = inhibit_q;
    if (clear_i) begin
      error_d = 1'b0;
      halted_d = halt_i;
      if (cancel_inhibit_i) begin
        inhibit_d = 1'b0;
      end
    end
    // New events win over a clear in the same cycle
    if (error_set_i) begin
      error_d = 1'b1;
    end
    if (inhibit_set_i) begin
      inhibit_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      halted_q <= 1'b0;
      error_q <= 1'b0;
      inhibit_q <= 1'b0;
    end else if (clk_en_i) begin
      halted_q <= halted_d;
      error_q <= error_d;
      inhibit_q <= inhibit_d;
    end
  end

  assign halted_o = halted_q;
  assign error_o = error_q;
  assign inhibit_o = inhibit_q;
endmodule

/* hdl/assrc_top.sv */
// Command interpreter: emergency halt, error clear, state record read
//
// Behaviour
// - An emergency halt command stops the axis named by its axis operand.
// - A halted axis gates its pulse output off at once with no ramp.
// - Axis operand 0 selects axis X and 1 selects axis Y.
// - An error clear command clears the latched error of the addressed axis.
// - Third operand 0 keeps output inhibition, 1 cancels it with the clear.
// - A state read samples the axis state and writes consecutive host words from operand three.
// - Record order: up, down, info, io, position, speed, step, M code, error, encoder.
// - A memory read from the axis X state base returns the same record words.
`timescale 1ns/10ps
module assrc_top (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic cmd_valid_i,
  input wire logic [1:0] cmd_code_i,
  input wire logic [15:0] slot_operand_i,
  input wire logic [15:0] axis_select_operand_i,
  input wire logic [15:0] third_operand_i,
  input wire logic [15:0] my_slot_i,
  input wire logic [1:0] axis_error_set_i,
  input wire logic [1:0] axis_inhibit_set_i,
  input wire logic [1:0] pulse_req_i,
  input wire logic [31:0] state_bits_x_i,
  input wire logic [31:0] state_bits_y_i,
  input wire logic [15:0] axis_info_x_i,
  input wire logic [15:0] axis_info_y_i,
  input wire logic [15:0] ext_io_x_i,
  input wire logic [15:0] ext_io_y_i,
  input wire logic [31:0] position_x_i,
  input wire logic [31:0] position_y_i,
  input wire logic [31:0] speed_x_i,
  input wire logic [31:0] speed_y_i,
  input wire logic [15:0] step_x_i,
  input wire logic [15:0] step_y_i,
  input wire logic [15:0] mcode_x_i,
  input wire logic [15:0] mcode_y_i,
  input wire logic [15:0] err_code_x_i,
  input wire logic [15:0] err_code_y_i,
  input wire logic [31:0] encoder_x_i,
  input wire logic [31:0] encoder_y_i,
  output logic cmd_busy_o,
  output logic cmd_done_o,
  output logic cmd_error_o,
  output logic [1:0] halted_o,
  output logic [1:0] error_o,
  output logic [1:0] inhibit_o,
  output logic [1:0] pulse_o,
  output logic host_wr_o,
  output logic [15:0] host_addr_o,
  output logic [15:0] host_data_o
);
  assrc_pkg::assrc_state_t st_q, st_d;
  logic [15:0] rec_q [0:12];
  logic [15:0] rec_d [0:12];
  logic [3:0] idx_q, idx_d;
  logic [15:0] base_q, base_d;
  logic busy_q, busy_d, done_q, done_d, cerr_q, cerr_d;
  logic wr_q, wr_d;
  logic [15:0] addr_q, addr_d, data_q, data_d;
  logic [1:0] pulse_q, pulse_d;
  logic [1:0] halt_p, clear_p, halted, err, inh;
  logic accept, sel_y, rec_y, slot_ok, axis_ok, cancel;
  logic [15:0] mem_off;

  assign slot_ok = (slot_operand_i == my_slot_i);
  // Axis decode 0 = X, 1 = Y
  assign axis_ok = (axis_select_operand_i[15:1] == 15'h0000);
  assign sel_y = (axis_select_operand_i[1:0] == assrc_pkg::ASSRC_AXIS_Y);
  assign accept = cmd_valid_i & (st_q == assrc_pkg::ASSRC_ST_IDLE) & slot_ok;
  assign cancel = (third_operand_i == assrc_pkg::ASSRC_INHIBIT_CANCEL);
  assign mem_off = third_operand_i - assrc_pkg::ASSRC_STATE_BASE_X;
  // Memory read takes its axis from the address, not the destination
  assign rec_y = (cmd_code_i == assrc_pkg::ASSRC_CMD_GET) ?
                 (mem_off >= assrc_pkg::ASSRC_STATE_SPAN) : sel_y;

  always_comb begin
    halt_p = 2'h0;
    clear_p = 2'h0;
    if (accept && axis_ok && cmd_code_i == assrc_pkg::ASSRC_CMD_HALT) begin
      halt_p[sel_y] = 1'b1;
    end
    if (accept && axis_ok && cmd_code_i == assrc_pkg::ASSRC_CMD_CLEAR) begin
      clear_p[sel_y] = 1'b1;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_axis
      assrc_axis_flags u_flags (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .clk_en_i(clk_en_i),
        .halt_i(halt_p[g]),
        .clear_i(clear_p[g]),
        .cancel_inhibit_i(cancel),
        .error_set_i(axis_error_set_i[g]),
        .inhibit_set_i(axis_inhibit_set_i[g]),
        .halted_o(halted[g]),
        .error_o(err[g]),
        .inhibit_o(inh[g])
      );
    end
  endgenerate

  // Pulses cut the same edge a halt is taken
  assign pulse_d = pulse_req_i & ~halted & ~halt_p & ~inh;

  always_comb begin
    st_d = st_q;
    idx_d = idx_q;
    base_d = base_q;
    busy_d = busy_q;
    done_d = 1'b0;
    cerr_d = 1'b0;
    wr_d = 1'b0;
    addr_d = addr_q;
    data_d = data_q;
    for (int i = 0; i < 13; i++) begin
      rec_d[i] = rec_q[i];
    end
    case (st_q)
      assrc_pkg::ASSRC_ST_IDLE: begin
        if (cmd_valid_i && !accept) begin
          cerr_d = 1'b0;
        end
        // Memory read carries a destination in the axis operand
        if (accept && !axis_ok && cmd_code_i != assrc_pkg::ASSRC_CMD_GET) begin
          cerr_d = 1'b1;
          done_d = 1'b1;
        end else if (accept && (cmd_code_i == assrc_pkg::ASSRC_CMD_HALT ||
                                cmd_code_i == assrc_pkg::ASSRC_CMD_CLEAR)) begin
          done_d = 1'b1;
        end else if (accept) begin
          // Snapshot whole record in one cycle
          rec_d[assrc_pkg::ASSRC_W_UP] = rec_y ? state_bits_y_i[31:16] : state_bits_x_i[31:16];
          rec_d[assrc_pkg::ASSRC_W_DOWN] = rec_y ? state_bits_y_i[15:0] : state_bits_x_i[15:0];
          rec_d[assrc_pkg::ASSRC_W_INFO] = rec_y ? axis_info_y_i : axis_info_x_i;
          rec_d[assrc_pkg::ASSRC_W_IO] = rec_y ? ext_io_y_i : ext_io_x_i;
          rec_d[assrc_pkg::ASSRC_W_POS_LO] = rec_y ? position_y_i[15:0] : position_x_i[15:0];
          rec_d[assrc_pkg::ASSRC_W_POS_HI] = rec_y ? position_y_i[31:16] : position_x_i[31:16];
          rec_d[assrc_pkg::ASSRC_W_SPD_LO] = rec_y ? speed_y_i[15:0] : speed_x_i[15:0];
          rec_d[assrc_pkg::ASSRC_W_SPD_HI] = rec_y ? speed_y_i[31:16] : speed_x_i[31:16];
          rec_d[assrc_pkg::ASSRC_W_STEP] = rec_y ? step_y_i : step_x_i;
          rec_d[assrc_pkg::ASSRC_W_MCODE] = rec_y ? mcode_y_i : mcode_x_i;
          rec_d[assrc_pkg::ASSRC_W_ERR] = rec_y ? err_code_y_i : err_code_x_i;
          rec_d[assrc_pkg::ASSRC_W_ENC_LO] = rec_y ? encoder_y_i[15:0] : encoder_x_i[15:0];
          rec_d[assrc_pkg::ASSRC_W_ENC_HI] = rec_y ? encoder_y_i[31:16] : encoder_x_i[31:16];
          base_d = third_operand_i;
          idx_d = 4'h0;
          if (cmd_code_i == assrc_pkg::ASSRC_CMD_GET) begin
            // Memory read maps onto the record; Y follows X by one span
            if (mem_off < assrc_pkg::ASSRC_STATE_SPAN + {12'h000, assrc_pkg::ASSRC_REC_WORDS}
                && (mem_off < {12'h000, assrc_pkg::ASSRC_REC_WORDS} ||
                    mem_off >= assrc_pkg::ASSRC_STATE_SPAN)) begin
              base_d = axis_select_operand_i;
              idx_d = (mem_off >= assrc_pkg::ASSRC_STATE_SPAN) ?
                      mem_off[3:0] - assrc_pkg::ASSRC_STATE_SPAN[3:0] : mem_off[3:0];
              st_d = assrc_pkg::ASSRC_ST_SEND;
              busy_d = 1'b1;
            end else begin
              cerr_d = 1'b1;
              done_d = 1'b1;
            end
          end else begin
            st_d = assrc_pkg::ASSRC_ST_SEND;
            busy_d = 1'b1;
          end
        end
      end
      assrc_pkg::ASSRC_ST_SEND: begin
        wr_d = 1'b1;
        addr_d = base_q;
        data_d = rec_q[idx_q];
        base_d = base_q + 16'h0001;
        idx_d = idx_q + 4'h1;
        if (idx_q == assrc_pkg::ASSRC_REC_LAST) begin
          st_d = assrc_pkg::ASSRC_ST_DONE;
        end
      end
      assrc_pkg::ASSRC_ST_DONE: begin
        busy_d = 1'b0;
        done_d = 1'b1;
        st_d = assrc_pkg::ASSRC_ST_IDLE;
      end
      default: begin
        st_d = assrc_pkg::ASSRC_ST_IDLE;
        busy_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      st_q <= assrc_pkg::ASSRC_ST_IDLE;
      idx_q <= 4'h0;
      base_q <= assrc_pkg::ASSRC_WORD_RESET;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      cerr_q <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= assrc_pkg::ASSRC_WORD_RESET;
      data_q <= assrc_pkg::ASSRC_WORD_RESET;
      pulse_q <= 2'h0;
      for (int i = 0; i < 13; i++) begin
        rec_q[i] <= assrc_pkg::ASSRC_WORD_RESET;
      end
    end else if (clk_en_i) begin
      st_q <= st_d;
      idx_q <= idx_d;
      base_q <= base_d;
      busy_q <= busy_d;
      done_q <= done_d;
      cerr_q <= cerr_d;
      wr_q <= wr_d;
      addr_q <= addr_d;
      data_q <= data_d;
      pulse_q <= pulse_d;
      for (int i = 0; i < 13; i++) begin
        rec_q[i] <= rec_d[i];
      end
    end
  end

  assign cmd_busy_o = busy_q;
  assign cmd_done_o = done_q;
  assign cmd_error_o = cerr_q;
  assign halted_o = halted;
  assign error_o = err;
  assign inhibit_o = inh;
  assign pulse_o = pulse_q;
  assign host_wr_o = wr_q;
  assign host_addr_o = addr_q;
  assign host_data_o = data_q;
endmodule

/* verif/assrc_asserts.sv */
// Port checker for the halt, clear and state record command block
`timescale 1ns/10ps
module assrc_asserts (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire logic cmd_valid_i,
  input wire logic [1:0] cmd_code_i,
  input wire logic [15:0] slot_operand_i,
  input wire logic [15:0] axis_select_operand_i,
  input wire logic [15:0] third_operand_i,
  input wire logic [15:0] my_slot_i,
  input wire logic [1:0] axis_error_set_i,
  input wire logic [1:0] axis_inhibit_set_i,
  input wire logic cmd_busy_o,
  input wire logic cmd_done_o,
  input wire logic cmd_error_o,
  input wire logic [1:0] halted_o,
  input wire logic [1:0] error_o,
  input wire logic [1:0] inhibit_o,
  input wire logic [1:0] pulse_o,
  input wire logic host_wr_o,
  input wire logic [15:0] host_addr_o
);
  logic take;
  logic halt;
  logic clr0;
  assign take = clk_en_i && cmd_valid_i && !cmd_busy_o && slot_operand_i == my_slot_i;
  assign halt = take && cmd_code_i == assrc_pkg::ASSRC_CMD_HALT;
  assign clr0 = take && cmd_code_i == assrc_pkg::ASSRC_CMD_CLEAR && axis_select_operand_i == 0;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_start;
    take && cmd_code_i == assrc_pkg::ASSRC_CMD_SRD && axis_select_operand_i <= 16'h0001;
  endsequence
  // Thirteen words, too many for one repetition
  sequence s_words;
    host_wr_o [*8] ##1 host_wr_o [*5];
  endsequence
  a_halt_x_stop: assert property (halt && axis_select_operand_i == 0 |=>
    halted_o[0] && !pulse_o[0] && cmd_done_o) else $error("axis x not halted");
  a_halt_y_stop: assert property (halt && axis_select_operand_i == 1 |=>
    halted_o[1] && !pulse_o[1] && cmd_done_o) else $error("axis y not halted");
  a_halted_no_pulse: assert property (halted_o[0] |-> !pulse_o[0])
    else $error("pulse while halted");
  a_clear_error: assert property (clr0 && !axis_error_set_i[0] |=>
    !error_o[0] && !halted_o[0]) else $error("error not cleared");
  a_inhibit_kept: assert property (clr0 && third_operand_i != 1 && inhibit_o[0] |=>
    inhibit_o[0]) else $error("inhibit dropped");
  a_inhibit_lifted: assert property (clr0 && third_operand_i == 1 && !axis_inhibit_set_i[0]
    |=> !inhibit_o[0]) else $error("inhibit kept");
  a_record_walk: assert property (s_start |=> cmd_busy_o ##1
    host_addr_o == $past(third_operand_i, 2) ##0 s_words ##1 cmd_done_o)
    else $error("record walk wrong");
  a_bad_axis: assert property (take && cmd_code_i != assrc_pkg::ASSRC_CMD_GET &&
    axis_select_operand_i > 1 |=> cmd_done_o && cmd_error_o) else $error("bad axis accepted");
  a_write_busy: assert property (host_wr_o |-> cmd_busy_o) else $error("write while idle");
endmodule
bind assrc_top assrc_asserts u_chk (.ref_clk_i, .sys_rst_i, .clk_en_i, .cmd_valid_i,
  .cmd_code_i, .slot_operand_i, .axis_select_operand_i, .third_operand_i, .my_slot_i,
  .axis_error_set_i, .axis_inhibit_set_i, .cmd_busy_o, .cmd_done_o, .cmd_error_o, .halted_o,
  .error_o, .inhibit_o, .pulse_o, .host_wr_o, .host_addr_o);

/* verif/assrc_host_mem.sv */
// Host memory model that captures words written by the block
`timescale 1ns/10ps
module assrc_host_mem (
  input wire logic ref_clk_i,
  input wire logic host_wr_i,
  input wire logic [15:0] host_addr_i,
  input wire logic [15:0] host_data_i
);
  logic [15:0] mem [0:255];
  always @(posedge ref_clk_i) begin
    if (host_wr_i) begin
      mem[host_addr_i[7:0]] <= host_data_i;
    end
  end
endmodule

/* verif/tb_top.sv */
// Self-checking bench for the halt, clear and state record commands
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_total++; \
  $display("unexpected %0t got %h exp %h", $time, a, b); end end
module tb_top;
  logic clk = 1'b0, rst = 1'b1, en = 1'b1, vld = 1'b0, seen;
  logic [1:0] code = 2'h0, eset = 2'h0, iset = 2'h0, preq = 2'h3;
  logic [15:0] slot = 16'h0003, axis = 16'h0000, op3 = 16'h0000;
  logic [7:0] bx = 8'h0a, by = 8'h0b;
  logic busy, done, cerr, wr;
  logic [1:0] halted, errs, inh, pulse;
  logic [15:0] addr, data;
  int err_total = 0, samples_checked = 0, cycles = 0;
  assrc_top uut (.ref_clk_i(clk), .sys_rst_i(rst), .clk_en_i(en), .cmd_valid_i(vld),
    .cmd_code_i(code), .slot_operand_i(slot), .axis_select_operand_i(axis),
    .third_operand_i(op3), .my_slot_i(16'h0003), .axis_error_set_i(eset),
    .axis_inhibit_set_i(iset), .pulse_req_i(preq), .state_bits_x_i({bx, 8'h00, bx, 8'h01}),
    .state_bits_y_i({by, 8'h00, by, 8'h01}), .axis_info_x_i({bx, 8'h02}),
    .axis_info_y_i({by, 8'h02}), .ext_io_x_i({bx, 8'h03}), .ext_io_y_i({by, 8'h03}),
    .position_x_i({bx, 8'h05, bx, 8'h04}), .position_y_i({by, 8'h05, by, 8'h04}),
    .speed_x_i({bx, 8'h07, bx, 8'h06}), .speed_y_i({by, 8'h07, by, 8'h06}),
    .step_x_i({bx, 8'h08}), .step_y_i({by, 8'h08}), .mcode_x_i({bx, 8'h09}),
    .mcode_y_i({by, 8'h09}), .err_code_x_i({bx, 8'h0a}), .err_code_y_i({by, 8'h0a}),
    .encoder_x_i({bx, 8'h0c, bx, 8'h0b}), .encoder_y_i({by, 8'h0c, by, 8'h0b}),
    .cmd_busy_o(busy), .cmd_done_o(done), .cmd_error_o(cerr), .halted_o(halted),
    .error_o(errs), .inhibit_o(inh), .pulse_o(pulse), .host_wr_o(wr), .host_addr_o(addr),
    .host_data_o(data));
  assrc_host_mem host (.ref_clk_i(clk), .host_wr_i(wr), .host_addr_i(addr),
    .host_data_i(data));
  always #2.5 clk = ~clk;
  task automatic stop_test();
    if (err_total == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_total++;
      stop_test();
    end
  end
  // Issue one command, then wait a bounded time for its done pulse
  task automatic cmd(input logic [1:0] c, input logic [15:0] a, input logic [15:0] o3);
    int i;
    @(posedge clk);
    vld <= 1'b1;
    code <= c;
    axis <= a;
    op3 <= o3;
    @(posedge clk);
    vld <= 1'b0;
    #1;
    // Always return just after an edge, never inside one
    for (i = 0; i < 20 && done !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    seen = (done === 1'b1);
  endtask
  task automatic chk_rec(input logic [15:0] dst, input logic [7:0] b);
    logic [7:0] ix;
    for (int k = 0; k < 13; k++) begin
      ix = dst[7:0] + 8'(k);
      `CHK(host.mem[ix], {b, 8'(k)})
    end
  endtask
  task automatic t_halt();
    cmd(assrc_pkg::ASSRC_CMD_HALT, 16'h0000, 16'h0000);
    `CHK(halted, 2'b01)
    `CHK(pulse, 2'b10)
    cmd(assrc_pkg::ASSRC_CMD_HALT, 16'h0001, 16'h0000);
    `CHK(halted, 2'b11)
    `CHK(pulse, 2'b00)
  endtask
  task automatic t_clear();
    @(posedge clk);
    eset <= 2'b01;
    iset <= 2'b01;
    @(posedge clk);
    eset <= 2'b00;
    iset <= 2'b00;
    @(posedge clk);
    #1;
    `CHK(errs, 2'b01)
    cmd(assrc_pkg::ASSRC_CMD_CLEAR, 16'h0000, 16'h0000);
    `CHK(errs, 2'b00)
    `CHK(halted, 2'b10)
    `CHK(inh, 2'b01)
    cmd(assrc_pkg::ASSRC_CMD_CLEAR, 16'h0000, 16'h0001);
    `CHK(inh, 2'b00)
    repeat (2) @(posedge clk);
    #1;
    `CHK(pulse, 2'b01)
    cmd(assrc_pkg::ASSRC_CMD_CLEAR, 16'h0001, 16'h0001);
    `CHK(halted, 2'b00)
  endtask
  task automatic t_refuse();
    cmd(assrc_pkg::ASSRC_CMD_HALT, 16'h0002, 16'h0000);
    `CHK(cerr, 1'b1)
    `CHK(seen, 1'b1)
    @(posedge clk);
    slot <= 16'h0004;
    cmd(assrc_pkg::ASSRC_CMD_HALT, 16'h0000, 16'h0000);
    `CHK(seen, 1'b0)
    `CHK(halted, 2'b00)
    @(posedge clk);
    slot <= 16'h0003;
    en <= 1'b0;
    cmd(assrc_pkg::ASSRC_CMD_HALT, 16'h0000, 16'h0000);
    `CHK(seen, 1'b0)
    `CHK(halted, 2'b00)
    @(posedge clk);
    en <= 1'b1;
  endtask
  task automatic t_record();
    cmd(assrc_pkg::ASSRC_CMD_SRD, 16'h0001, 16'h0040);
    chk_rec(16'h0040, by);
    @(posedge clk);
    bx <= 8'h5a;
    cmd(assrc_pkg::ASSRC_CMD_SRD, 16'h0000, 16'h0080);
    chk_rec(16'h0080, 8'h5a);
    cmd(assrc_pkg::ASSRC_CMD_GET, 16'h00a0, assrc_pkg::ASSRC_STATE_BASE_X);
    chk_rec(16'h00a0, 8'h5a);
    cmd(assrc_pkg::ASSRC_CMD_GET, 16'h00c0,
        assrc_pkg::ASSRC_STATE_BASE_X + assrc_pkg::ASSRC_STATE_SPAN);
    chk_rec(16'h00c0, by);
    cmd(assrc_pkg::ASSRC_CMD_GET, 16'h00e0, assrc_pkg::ASSRC_STATE_BASE_X + 16'h0010);
    `CHK(cerr, 1'b1)
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    t_halt();
    t_clear();
    t_refuse();
    t_record();
    stop_test();
  end
endmodule
